/* File: shared/scf_pkg.sv */
// constants for the system clock select and failover block
// assumes one 50 MHz clock and an apb master reaching the registers
//
// Functional notes
// - control changes need the unlock writes E7H then 18H, tracked in order
// - the next control write after unlock stores its value and relocks
// - any other control write sequence leaves the contents unchanged
// - unlock writes need order only; other register accesses do not break it
// - selecting another source never clears the precision oscillator enable
// - primary failure with detection on raises an event and forces watchdog
// - forced switch needs watchdog oscillator enabled, not watchdog reset
// - primary failure flagged when the system clock level holds for about 1 ms
// - watchdog oscillator failure raises an event, source stays unchanged
// - after watchdog oscillator failure primary detection stops working
// - watchdog failure declared after 8004 clocks without a watchdog edge
// - bit 7 enables the precision oscillator, resets to 1
// - bit 6 enables the crystal and overrides the crystal pin gpio, reset 0
// - bit 4 enables sysclk failure detection (reset 0), bit 5 watchdog osc
// - bit 3 enables watchdog oscillator failure detection, resets to 0
// - bits 2:0 select fast rc, slow rc, crystal, watchdog, ext pin
// - option bit at 0 keeps crystal running from reset, at 1 crystal waits for bit 6
package scf_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [11:0] OSC_CONTROL_IDX = 12'hF86;
    localparam logic [11:0] OSC_STATUS_IDX = 12'hF87;
    localparam logic [13:0] OSC_CONTROL_ADDR = {OSC_CONTROL_IDX, 2'h0};
    localparam logic [13:0] OSC_STATUS_ADDR = {OSC_STATUS_IDX, 2'h0};
    localparam logic [7:0] OSC_CONTROL_RESET = 8'hA0;
    localparam logic [7:0] UNLOCK_FIRST = 8'hE7;
    localparam logic [7:0] UNLOCK_SECOND = 8'h18;
    // control fields
    localparam int BIT_IRC_EN = 7;
    localparam int BIT_XTAL_EN = 6;
    localparam int BIT_WDT_EN = 5;
    localparam int BIT_SYS_FD = 4;
    localparam int BIT_WDT_FD = 3;
    // status fields
    localparam int BIT_ST_SYS_FAIL = 7;
    localparam int BIT_ST_WDT_FAIL = 6;
    localparam int BIT_ST_RECOVER = 5;
    localparam int BIT_ST_SWITCH = 4;
    localparam int BIT_ST_UNLOCK = 3;
    // source codes
    localparam logic [2:0] SRC_IRC_FAST = 3'h0;
    localparam logic [2:0] SRC_IRC_SLOW = 3'h1;
    localparam logic [2:0] SRC_XTAL = 3'h2;
    localparam logic [2:0] SRC_WDT = 3'h3;
    localparam logic [2:0] SRC_EXT = 3'h4;
    localparam int NUM_SRC = 5;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int SYS_FAIL_TIME_NS = 1000000;
    localparam int SYS_FAIL_CYCLES = SYS_FAIL_TIME_NS / CLK_PERIOD_NS;
    localparam int WDT_FAIL_CYCLES = 8004;
    localparam int SWITCH_GAP_CYCLES = 4;
    // unlock tracker states
    typedef enum logic [2:0] {
        LK_LOCKED = 3'h1,
        LK_HALF = 3'h2,
        LK_OPEN = 3'h4
    } scf_lock_t;
endpackage : scf_pkg

/* File: hdl/scf_top.sv */
// system clock select and failover logic with its apb register file
// assumes apb inputs and oscillator activity levels synchronous to clk
//
// Added by the designer: the APB register port.
`default_nettype none
module scf_top #(
    parameter int SYS_FAIL_CYCLES = scf_pkg::SYS_FAIL_CYCLES,
    parameter int WDT_FAIL_CYCLES = scf_pkg::WDT_FAIL_CYCLES,
    parameter int SWITCH_GAP = scf_pkg::SWITCH_GAP_CYCLES
) (
    input wire logic clk, // 50 MHz clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [13:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic sysclk_level, // selected clock, sampled
    input wire logic wdt_osc_level, // watchdog oscillator, sampled
    input wire logic xtal_disable_option, // option bit, 1 keeps crystal off
    output logic internal_rc_enable, // precision rc oscillator enable
    output logic internal_rc_slow, // precision rc in slow mode
    output logic xtal_osc_enable, // crystal oscillator runs
    output logic xtal_pin_override, // crystal owns both crystal pins
    output logic wdt_osc_enable, // watchdog oscillator enable
    output logic [4:0] sysclk_gate, // one-hot clock mux gates
    output logic sys_fail_event, // pulse on primary clock failure
    output logic wdt_fail_event // pulse on watchdog osc failure
);
    // ************************************************************
    // parameter checks
    // ************************************************************
    // refuse counts that the 16-bit and 8-bit counters cannot hold
    if (SYS_FAIL_CYCLES < 2 || SYS_FAIL_CYCLES > 65535) begin : g_bad_sys
        $error("SYS_FAIL_CYCLES out of range");
    end

    if (WDT_FAIL_CYCLES < 2 || WDT_FAIL_CYCLES > 65535) begin : g_bad_wdt
        $error("WDT_FAIL_CYCLES out of range");
    end

    if (SWITCH_GAP < 1 || SWITCH_GAP > 255) begin : g_bad_gap
        $error("SWITCH_GAP out of range");
    end

    // last count of each counter before it trips
    localparam logic [15:0] SYS_LIMIT = 16'(SYS_FAIL_CYCLES - 1);
    localparam logic [15:0] WDT_LIMIT = 16'(WDT_FAIL_CYCLES - 1);
    localparam logic [7:0] GAP_LIMIT = 8'(SWITCH_GAP - 1);

    // turns a source code into its mux gate
    function automatic logic [4:0] src_onehot(input logic [2:0] code);
        logic [4:0] oh;
        oh = 5'h00;
        if (code < 3'(scf_pkg::NUM_SRC))
            oh[code] = 1'b1;
        return oh;
    endfunction

    // ************************************************************
    // apb decode
    // ************************************************************
    logic setup;
    logic access;
    logic hit_ctl;
    logic hit_st;
    logic wr_ctl;
    logic wr_st;
    logic [7:0] wbyte;

    // decode of the transfer on the bus
    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign hit_ctl = (paddr == scf_pkg::OSC_CONTROL_ADDR);
    assign hit_st = (paddr == scf_pkg::OSC_STATUS_ADDR);
    assign wr_ctl = access & pwrite & hit_ctl;
    assign wr_st = access & pwrite & hit_st;
    assign wbyte = pwdata[7:0];

    // ************************************************************
    // unlock tracker
    // ************************************************************
    // tracker state and the control write that may store
    scf_pkg::scf_lock_t lock_q;
    logic store_ctl;

    // only control writes move the tracker; other accesses leave it
    assign store_ctl = wr_ctl & (lock_q == scf_pkg::LK_OPEN);

    // ordered two-write unlock, relock after one data write
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lock_q <= scf_pkg::LK_LOCKED;
        end else if (wr_ctl) begin
            case (lock_q)
                scf_pkg::LK_LOCKED: begin
                    if (wbyte == scf_pkg::UNLOCK_FIRST)
                        lock_q <= scf_pkg::LK_HALF;
                end
                scf_pkg::LK_HALF: begin
                    if (wbyte == scf_pkg::UNLOCK_SECOND)
                        lock_q <= scf_pkg::LK_OPEN;
                    else
                        lock_q <= scf_pkg::LK_LOCKED;
                end
                scf_pkg::LK_OPEN: begin
                    lock_q <= scf_pkg::LK_LOCKED;
                end
                default: begin
                    lock_q <= scf_pkg::LK_LOCKED;
                end
            endcase
        end
    end

    // ************************************************************
    // control register
    // ************************************************************
    // stored control value behind the unlock guard
    logic [7:0] ctl_q;

    // contents change only on the write after a full unlock
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctl_q <= scf_pkg::OSC_CONTROL_RESET;
        end else if (store_ctl) begin
            ctl_q <= wbyte;
        end
    end

    // ************************************************************
    // crystal run from reset
    // ************************************************************
    logic xtal_keep_q;

    // option level caught while reset is held, dropped by software
    always_ff @(posedge clk) begin
        if (!rstn) begin
            xtal_keep_q <= ~xtal_disable_option;
        end else if (store_ctl && !wbyte[scf_pkg::BIT_XTAL_EN]) begin
            xtal_keep_q <= 1'b0;
        end
    end

    // ************************************************************
    // failure detection
    // ************************************************************
    // edge history, idle counters, flags and the running source
    logic sys_prev_q;
    logic wdt_prev_q;
    logic [15:0] sys_cnt_q;
    logic [15:0] wdt_cnt_q;
    logic sys_fail_q;
    logic wdt_fail_q;
    logic recover_q;
    logic [2:0] cur_src_q;
    logic sys_watch;
    logic wdt_watch;
    logic sys_hit;
    logic wdt_hit;

    // primary watch stops while the watchdog osc failure flag stays set
    assign sys_watch = ctl_q[scf_pkg::BIT_SYS_FD] & ~wdt_fail_q
        & ~recover_q;
    assign wdt_watch = ctl_q[scf_pkg::BIT_WDT_FD]
        & ctl_q[scf_pkg::BIT_WDT_EN] & (cur_src_q != scf_pkg::SRC_WDT);
    // a set flag holds off repeats, so each failure gives one pulse
    // until software clears the flag with a write of one
    assign sys_hit = sys_watch & ~sys_fail_q & (sys_cnt_q == SYS_LIMIT);
    assign wdt_hit = wdt_watch & ~wdt_fail_q & (wdt_cnt_q == WDT_LIMIT);

    // edge history of the sampled clocks
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sys_prev_q <= 1'b0;
            wdt_prev_q <= 1'b0;
        end else begin
            sys_prev_q <= sysclk_level;
            wdt_prev_q <= wdt_osc_level;
        end
    end

    // cycles since the last system clock edge, about 1 ms trips
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sys_cnt_q <= 16'h0000;
        end else if (!sys_watch || (sysclk_level != sys_prev_q)) begin
            sys_cnt_q <= 16'h0000;
        end else if (sys_cnt_q != SYS_LIMIT) begin
            sys_cnt_q <= sys_cnt_q + 16'h0001;
        end
    end

    // cycles since the last watchdog oscillator edge
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wdt_cnt_q <= 16'h0000;
        end else if (!wdt_watch || (wdt_osc_level != wdt_prev_q)) begin
            wdt_cnt_q <= 16'h0000;
        end else if (wdt_cnt_q != WDT_LIMIT) begin
            wdt_cnt_q <= wdt_cnt_q + 16'h0001;
        end
    end

    // sticky failure flags, a new failure beats a write-one clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sys_fail_q <= 1'b0;
        end else if (sys_hit) begin
            sys_fail_q <= 1'b1;
        end else if (wr_st && wbyte[scf_pkg::BIT_ST_SYS_FAIL]) begin
            sys_fail_q <= 1'b0;
        end
    end

    // the watchdog failure flag also blocks primary detection
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wdt_fail_q <= 1'b0;
        end else if (wdt_hit) begin
            wdt_fail_q <= 1'b1;
        end else if (wr_st && wbyte[scf_pkg::BIT_ST_WDT_FAIL]) begin
            wdt_fail_q <= 1'b0;
        end
    end

    // one-cycle failure events
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sys_fail_event <= 1'b0;
            wdt_fail_event <= 1'b0;
        end else begin
            sys_fail_event <= sys_hit;
            wdt_fail_event <= wdt_hit;
        end
    end

    // forced watchdog source, held until software stores a new control
    always_ff @(posedge clk) begin
        if (!rstn) begin
            recover_q <= 1'b0;
        end else if (sys_hit && ctl_q[scf_pkg::BIT_WDT_EN]) begin
            recover_q <= 1'b1;
        end else if (store_ctl) begin
            recover_q <= 1'b0;
        end
    end

    // ************************************************************
    // clock source switch
    // ************************************************************
    // target source, gap counter and switch in progress
    logic [2:0] target;
    logic [7:0] gap_q;
    logic switching_q;
    logic [2:0] field;

    // reserved codes keep the running source
    assign field = ctl_q[2:0];
    always_comb begin
        if (recover_q)
            target = scf_pkg::SRC_WDT;
        else if (field > scf_pkg::SRC_EXT)
            target = cur_src_q;
        else
            target = field;
    end

    // break before make: all gates off for the gap, then the new one
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cur_src_q <= scf_pkg::SRC_IRC_FAST;
            switching_q <= 1'b0;
            gap_q <= 8'h00;
            sysclk_gate <= src_onehot(scf_pkg::SRC_IRC_FAST);
        end else if (switching_q) begin
            if (gap_q == GAP_LIMIT) begin
                switching_q <= 1'b0;
                gap_q <= 8'h00;
                cur_src_q <= target;
                sysclk_gate <= src_onehot(target);
            end else begin
                gap_q <= gap_q + 8'h01;
            end
        end else if (target != cur_src_q) begin
            switching_q <= 1'b1;
            sysclk_gate <= 5'h00;
        end
    end

    // ************************************************************
    // oscillator enables
    // ************************************************************
    // enables follow the register, the crystal one also the option level caught at reset, while rc slow mode follows the running source
    always_ff @(posedge clk) begin
        if (!rstn) begin
            internal_rc_enable <= 1'b1;
            internal_rc_slow <= 1'b0;
            xtal_osc_enable <= 1'b0;
            xtal_pin_override <= 1'b0;
            wdt_osc_enable <= 1'b1;
        end else begin
            internal_rc_enable <= ctl_q[scf_pkg::BIT_IRC_EN];
            internal_rc_slow <= (cur_src_q == scf_pkg::SRC_IRC_SLOW);
            xtal_osc_enable <= ctl_q[scf_pkg::BIT_XTAL_EN]
                | xtal_keep_q;
            xtal_pin_override <= ctl_q[scf_pkg::BIT_XTAL_EN];
            wdt_osc_enable <= ctl_q[scf_pkg::BIT_WDT_EN];
        end
    end

    // ************************************************************
    // apb answer
    // ************************************************************
    logic [7:0] status;

    // status word: flags, recovery, switch, unlock, running source
    assign status = {sys_fail_q, wdt_fail_q, recover_q, switching_q,
        (lock_q == scf_pkg::LK_OPEN), cur_src_q};

    // one wait-free access phase; data and error set up in setup cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= ~(hit_ctl | hit_st);
            if (hit_ctl)
                prdata <= {24'h000000, ctl_q};
            else if (hit_st)
                prdata <= {24'h000000, status};
            else
                prdata <= 32'h00000000;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // scf_top
`default_nettype wire

/* File: verif/scf_assertions.sv */
// checker for the clock select block, watching top module ports only
// assumes a bind into scf_top that hands on both failure counts
`default_nettype none
module scf_checker #(
    parameter int SYS_FAIL_CYCLES = 40,
    parameter int WDT_FAIL_CYCLES = 20
) (
    input wire logic clk, // clock
    input wire logic rstn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [13:0] paddr, // apb address
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic sysclk_level, // sampled sysclk
    input wire logic wdt_osc_level, // sampled watchdog osc
    input wire logic internal_rc_enable, // rc enable
    input wire logic wdt_osc_enable, // watchdog osc enable
    input wire logic [4:0] sysclk_gate, // mux gates
    input wire logic sys_fail_event, // primary failure
    input wire logic wdt_fail_event // watchdog failure
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // helper logic
    // ************************************************************
    logic wr_acc;
    logic sys_lvl_q;
    logic wdt_lvl_q;
    int sys_cnt_q;
    int wdt_cnt_q;
    // a completed apb write
    assign wr_acc = psel && penable && pwrite && pready;
    // cycles since each sampled level last moved
    always_ff @(posedge clk) begin
        sys_lvl_q <= sysclk_level;
        wdt_lvl_q <= wdt_osc_level;
        if (!rstn || sysclk_level != sys_lvl_q)
            sys_cnt_q <= 0;
        else
            sys_cnt_q <= sys_cnt_q + 1;
        if (!rstn || wdt_osc_level != wdt_lvl_q)
            wdt_cnt_q <= 0;
        else
            wdt_cnt_q <= wdt_cnt_q + 1;
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    property p_setup_ready; psel && !penable |=> pready && penable; endproperty
    a_setup_ready: assert property (p_setup_ready)
        else $error("no ready after setup");
    property p_refuse;
        pready && paddr != scf_pkg::OSC_CONTROL_ADDR
            && paddr != scf_pkg::OSC_STATUS_ADDR |-> pslverr;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("unmapped access not refused");
    property p_gap_first;
        $changed(sysclk_gate) && sysclk_gate != 5'h00
            |-> $past(sysclk_gate) == 5'h00;
    endproperty
    a_gap_first: assert property (p_gap_first)
        else $error("gate switched without a gap");
    property p_gap_len; $fell(|sysclk_gate) |-> (sysclk_gate == 5'h00)[*4];
    endproperty
    a_gap_len: assert property (p_gap_len)
        else $error("switch gap too short");
    property p_onehot; $onehot0(sysclk_gate); endproperty
    a_onehot: assert property (p_onehot)
        else $error("more than one gate open");
    // enables sit two registers behind the completed write
    property p_rc_kept;
        $fell(internal_rc_enable) |-> $past(wr_acc, 2);
    endproperty
    a_rc_kept: assert property (p_rc_kept)
        else $error("rc enable dropped without a write");
    property p_wdt_en;
        $changed(wdt_osc_enable) |-> $past(wr_acc, 2);
    endproperty
    a_wdt_en: assert property (p_wdt_en)
        else $error("watchdog osc enable moved without a write");
    property p_recover;
        $rose(sys_fail_event) && wdt_osc_enable
            |-> ##[1:12] sysclk_gate == 5'h08;
    endproperty
    a_recover: assert property (p_recover)
        else $error("no switch to watchdog osc");
    property p_no_recover;
        sys_fail_event && !wdt_osc_enable |=> $stable(sysclk_gate)[*8];
    endproperty
    a_no_recover: assert property (p_no_recover)
        else $error("switch with watchdog osc off");
    property p_wdt_keep; wdt_fail_event |=> $stable(sysclk_gate)[*8];
    endproperty
    a_wdt_keep: assert property (p_wdt_keep)
        else $error("source moved on watchdog failure");
    property p_sys_cnt; sys_fail_event |-> sys_cnt_q >= SYS_FAIL_CYCLES - 1;
    endproperty
    a_sys_cnt: assert property (p_sys_cnt)
        else $error("primary failure too early");
    property p_wdt_cnt; wdt_fail_event |-> wdt_cnt_q >= WDT_FAIL_CYCLES - 1;
    endproperty
    a_wdt_cnt: assert property (p_wdt_cnt)
        else $error("watchdog failure too early");
    // main scenarios
    c_recover: cover property ($rose(sys_fail_event) && wdt_osc_enable);
    c_wdt_fail: cover property (wdt_fail_event);
    c_refuse: cover property (pready && pslverr);
endmodule // scf_checker
`default_nettype wire

/* File: verif/scf_top_test.sv */
// self-checking bench for the clock select block
// assumes scf_pkg, scf_top and scf_checker compiled first
`default_nettype none
module scf_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // signals and design
    // ************************************************************
    localparam logic [13:0] CA = scf_pkg::OSC_CONTROL_ADDR;
    localparam logic [13:0] SA = scf_pkg::OSC_STATUS_ADDR;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, e;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic sysclk_level, wdt_osc_level, xtal_disable_option, sys_run, wdt_run;
    logic internal_rc_enable, internal_rc_slow, xtal_osc_enable;
    logic xtal_pin_override, wdt_osc_enable, sys_fail_event, wdt_fail_event;
    logic [4:0] sysclk_gate;
    int n_mismatch, checks;
    scf_top #(.SYS_FAIL_CYCLES(40), .WDT_FAIL_CYCLES(20)) scf_top_i (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sysclk_level(sysclk_level),
        .wdt_osc_level(wdt_osc_level),
        .xtal_disable_option(xtal_disable_option),
        .internal_rc_enable(internal_rc_enable),
        .internal_rc_slow(internal_rc_slow),
        .xtal_osc_enable(xtal_osc_enable),
        .xtal_pin_override(xtal_pin_override),
        .wdt_osc_enable(wdt_osc_enable), .sysclk_gate(sysclk_gate),
        .sys_fail_event(sys_fail_event), .wdt_fail_event(wdt_fail_event)
    );
    // 50 mhz clock
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    // oscillator activity, stopped to fake a failure
    always @(posedge clk) begin
        if (sys_run)
            sysclk_level <= ~sysclk_level;
        if (wdt_run)
            wdt_osc_level <= ~wdt_osc_level;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, read data and error land in r and e
    task automatic apb(input logic w, input logic [13:0] a,
                       input logic [7:0] d);
        int i;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'h1 && i < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (i >= 20) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    task automatic ctl(input logic [7:0] v);
        apb(1'h1, CA, scf_pkg::UNLOCK_FIRST);
        apb(1'h1, CA, scf_pkg::UNLOCK_SECOND);
        apb(1'h1, CA, v);
    endtask
    // three control writes, then the control value read back
    task automatic try3(input logic [7:0] a, b, c);
        apb(1'h1, CA, a);
        apb(1'h1, CA, b);
        apb(1'h1, CA, c);
        apb(1'h0, CA, 8'h00);
    endtask
    task automatic wait_ev(input logic w, output int n);
        n = 0;
        #1;
        while ((w ? wdt_fail_event : sys_fail_event) !== 1'h1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 200) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    task automatic wgate(input logic [4:0] g);
        int i;
        i = 0;
        #1;
        while (sysclk_gate !== g && i < 30) begin
            @(posedge clk);
            #1;
            i++;
        end
        chk(sysclk_gate, g);
        if (i >= 30)
            end_sim();
    endtask
    task automatic do_reset(input logic o);
        @(posedge clk);
        xtal_disable_option <= o;
        rstn <= 1'h0;
        sys_run <= 1'h1;
        wdt_run <= 1'h1;
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        #1;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        do_reset(1'h0);
        chk(xtal_osc_enable, 1'h1);
        do_reset(1'h1);
        apb(1'h0, CA, 8'h00);
        chk(r, 32'hA0);
        chk({internal_rc_enable, wdt_osc_enable, xtal_osc_enable}, 3'h6);
        chk(sysclk_gate, 5'h01);
        apb(1'h1, 14'h0000, 8'h00);
        chk({e, r[7:0]}, 9'h100);
    endtask
    task automatic t_lock();
        try3(8'h55, 8'h18, 8'hA2);
        chk(r, 32'hA0);
        apb(1'h1, CA, scf_pkg::UNLOCK_FIRST);
        apb(1'h0, SA, 8'h00);
        apb(1'h1, CA, scf_pkg::UNLOCK_SECOND);
        apb(1'h0, SA, 8'h00);
        chk(r[3], 1'h1);
        try3(8'hA1, 8'hA2, 8'h55);
        chk(r, 32'hA1);
        try3(8'h18, 8'hE7, 8'hA2);
        chk(r, 32'hA1);
        try3(8'hE7, 8'h55, 8'hA2);
        chk(r, 32'hA1);
    endtask
    task automatic t_select();
        logic [4:0] g;
        logic [7:0] v;
        for (int c = 0; c < 6; c++) begin
            g = (c < 5) ? 5'h01 << c : 5'h10;
            // crystal enabled one step before it is selected
            v = ((c == 1 || c == 2) ? 8'hE0 : 8'hA0) | c[7:0];
            ctl(v);
            wgate(g);
            repeat (8) @(posedge clk);
            chk(sysclk_gate, g);
            chk({internal_rc_slow, xtal_pin_override, internal_rc_enable},
                {c == 1, c == 1 || c == 2, 1'h1});
        end
        ctl(8'h20);
        wgate(5'h01);
        chk(internal_rc_enable, 1'h0);
    endtask
    task automatic t_sysfail(input logic [7:0] v, input logic [4:0] g);
        int n;
        do_reset(1'h1);
        ctl(v);
        sys_run <= 1'h0;
        wait_ev(1'h0, n);
        chk(n >= 40 && n <= 50, 1'h1);
        repeat (15) @(posedge clk);
        #1;
        chk(sysclk_gate, g);
        apb(1'h0, SA, 8'h00);
        chk(r[7], 1'h1);
        apb(1'h1, SA, 8'h80);
        apb(1'h0, SA, 8'h00);
        chk(r[7], !v[5]);
    endtask
    task automatic t_wdtfail();
        int n;
        logic seen;
        do_reset(1'h1);
        ctl(8'hB8);
        wdt_run <= 1'h0;
        wait_ev(1'h1, n);
        chk(n >= 20 && n <= 30, 1'h1);
        @(posedge clk);
        sys_run <= 1'h0;
        seen = 1'h0;
        repeat (100) begin
            @(posedge clk);
            #1;
            seen = seen | sys_fail_event;
        end
        chk({seen, sysclk_gate}, 6'h01);
    endtask
    // main sequence
    initial begin
        rstn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 14'h0000;
        pwdata = 32'h0;
        sysclk_level = 1'h0;
        wdt_osc_level = 1'h0;
        xtal_disable_option = 1'h1;
        sys_run = 1'h0;
        wdt_run = 1'h0;
        n_mismatch = 0;
        checks = 0;
        t_reset();
        t_lock();
        t_select();
        t_sysfail(8'hB0, 5'h08);
        t_sysfail(8'h90, 5'h01);
        t_wdtfail();
        end_sim();
    end
endmodule // scf_top_test
bind scf_top scf_checker #(
    .SYS_FAIL_CYCLES(SYS_FAIL_CYCLES), .WDT_FAIL_CYCLES(WDT_FAIL_CYCLES)
) scf_checker_i (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .sysclk_level(sysclk_level), .wdt_osc_level(wdt_osc_level),
    .internal_rc_enable(internal_rc_enable),
    .wdt_osc_enable(wdt_osc_enable), .sysclk_gate(sysclk_gate),
    .sys_fail_event(sys_fail_event), .wdt_fail_event(wdt_fail_event)
);
`default_nettype wire
